// *** eiso_pkg.sv ***
// Constants, register map and carrier types for the event input and
// status output block.
// Assumes a single 125 MHz system clock and an APB register port.
package eiso_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_MHZ      = 125;
    // Filter periods in microseconds (3.9 ms, 15.6 ms, 125 ms)
    localparam int FILT1_US     = 3900;
    localparam int FILT2_US     = 15600;
    localparam int FILT3_US     = 125000;
    // Least active time when no filter is chosen
    localparam int NOFILT_US    = 60;
    localparam int FILT1_CYC    = FILT1_US * CLK_MHZ;
    localparam int FILT2_CYC    = FILT2_US * CLK_MHZ;
    localparam int FILT3_CYC    = FILT3_US * CLK_MHZ;
    // Strictly longer than the minimum, hence one cycle more
    localparam int NOFILT_CYC   = NOFILT_US * CLK_MHZ + 1;
    localparam int CNT_W        = 24;

    // ****************************************************************
    // Register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [5:0] IDX_FLAGS    = 6'h0E;
    localparam logic [5:0] IDX_EV_CTRL  = 6'h17;
    localparam logic [5:0] IDX_EV_DET   = 6'h18;
    localparam logic [5:0] IDX_KEY      = 6'h19;
    localparam logic [5:0] IDX_CFG      = 6'h1A;
    localparam logic [5:0] IDX_IRQ_STAT = 6'h20;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h21;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int FL_UPDATE   = 5;
    localparam int FL_TIMER    = 4;
    localparam int FL_ALARM    = 3;
    localparam int FL_SUPPLY   = 1;
    localparam int FL_LOWV     = 0;
    localparam int EC_CAPT     = 7;
    localparam int EC_LEVEL    = 6;
    localparam int EC_PULLUP   = 5;
    localparam int EC_REPEAT   = 4;
    localparam int EC_IRQ_EN   = 3;
    localparam int EC_DEB_HI   = 1;
    localparam int EC_DEB_LO   = 0;
    localparam int ED_HIST     = 7;
    localparam int ED_MON      = 3;
    localparam int CF_DIRECT   = 7;
    localparam int CF_LEVEL    = 6;
    localparam int CF_INVERT   = 3;
    localparam int CF_FS_HI    = 2;
    localparam int CF_FS_LO    = 0;
    localparam int IRQ_EVENT   = 0;
    localparam int IRQ_SUPPLY  = 1;
    localparam int IRQ_LOWV    = 2;
    localparam int IRQ_W       = 3;

    // ****************************************************************
    // Codes
    // ****************************************************************
    localparam logic [7:0] UNLOCK_KEY = 8'h69;
    localparam logic [1:0] DEB_NONE   = 2'h0;
    localparam logic [1:0] DEB_1      = 2'h1;
    localparam logic [1:0] DEB_2      = 2'h2;
    localparam logic [2:0] FS_TIMER   = 3'h0;
    localparam logic [2:0] FS_ALARM   = 3'h1;
    localparam logic [2:0] FS_UPDATE  = 3'h2;
    localparam logic [2:0] FS_LOWV    = 3'h4;
    localparam logic [2:0] FS_SUPPLY  = 3'h5;
    localparam logic [2:0] FS_HIST    = 3'h7;

    typedef enum logic [2:0] {
        EV_IDLE  = 3'b001,
        EV_COUNT = 3'b010,
        EV_HELD  = 3'b100
    } eiso_ev_state_t;

    // One-cycle set pulses from the flag generators outside
    typedef struct packed {
        logic update;
        logic timer;
        logic alarm;
        logic supply_loss;
        logic low_voltage;
    } eiso_flag_set_t;

    // Level interrupt requests of the other sources sharing the pin
    typedef struct packed {
        logic wakeup;
        logic alarm;
        logic update;
    } eiso_irq_req_t;

    typedef struct packed {
        eiso_ev_state_t     ev_state;
        logic [CNT_W-1:0]   cnt;
        logic [7:0]         flags;
        logic [7:0]         ev_ctrl;
        logic               hist;
        logic [7:0]         key;
        logic [7:0]         cfg;
        logic [IRQ_W-1:0]   irq_stat;
        logic [IRQ_W-1:0]   irq_mask;
        logic [31:0]        prdata;
        logic               pready;
        logic               pslverr;
        logic               int_oe;
        logic               status_o;
        logic               status_oe;
        logic               irq;
    } eiso_state_t;

endpackage

// *** eiso_core.sv ***
// Event input filter, event interrupt and status output pin logic with
// an APB register slave.
// Assumes the event pin is already synchronous to clk_sys and that an
// external pad turns the open-drain and tri-state enables into levels.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module eiso_core #(
    parameter int unsigned NOFILT_CYC = eiso_pkg::NOFILT_CYC,
    parameter int unsigned FILT1_CYC  = eiso_pkg::FILT1_CYC,
    parameter int unsigned FILT2_CYC  = eiso_pkg::FILT2_CYC,
    parameter int unsigned FILT3_CYC  = eiso_pkg::FILT3_CYC
) (
    input  wire logic                    clk_sys,
    input  wire logic                    sys_rst,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [7:0]              paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic                    event_input_pin,
    input  wire eiso_pkg::eiso_flag_set_t flag_set,
    input  wire eiso_pkg::eiso_irq_req_t  irq_req,
    output logic                         int_o,
    output logic                         int_oe,
    output logic                         status_output_pin_o,
    output logic                         status_output_pin_oe,
    output logic                         irq
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [eiso_pkg::CNT_W-1:0] deb_limit(
        input logic [1:0] code
    );
        logic [eiso_pkg::CNT_W-1:0] lim;
        lim = eiso_pkg::CNT_W'(FILT3_CYC);
        case (code)
            eiso_pkg::DEB_NONE: lim = eiso_pkg::CNT_W'(NOFILT_CYC);
            eiso_pkg::DEB_1:    lim = eiso_pkg::CNT_W'(FILT1_CYC);
            eiso_pkg::DEB_2:    lim = eiso_pkg::CNT_W'(FILT2_CYC);
            default:            lim = eiso_pkg::CNT_W'(FILT3_CYC);
        endcase
        return lim;
    endfunction

    function automatic logic sel_flag(
        input logic [2:0] fs,
        input logic [7:0] fl,
        input logic       hist
    );
        logic v;
        v = 1'b0;
        case (fs)
            eiso_pkg::FS_TIMER:  v = fl[eiso_pkg::FL_TIMER];
            eiso_pkg::FS_ALARM:  v = fl[eiso_pkg::FL_ALARM];
            eiso_pkg::FS_UPDATE: v = fl[eiso_pkg::FL_UPDATE];
            eiso_pkg::FS_LOWV:   v = fl[eiso_pkg::FL_LOWV];
            eiso_pkg::FS_SUPPLY: v = fl[eiso_pkg::FL_SUPPLY];
            eiso_pkg::FS_HIST:   v = hist;
            default:             v = 1'b0;
        endcase
        return v;
    endfunction

    function automatic logic fs_valid(input logic [2:0] fs);
        logic ok;
        ok = 1'b0;
        case (fs)
            eiso_pkg::FS_TIMER,
            eiso_pkg::FS_ALARM,
            eiso_pkg::FS_UPDATE,
            eiso_pkg::FS_LOWV,
            eiso_pkg::FS_SUPPLY,
            eiso_pkg::FS_HIST:   ok = 1'b1;
            default:             ok = 1'b0;
        endcase
        return ok;
    endfunction

    // Write-0-to-clear, with a same-cycle set winning over the clear
    function automatic logic w0c(
        input logic cur,
        input logic wr,
        input logic wbit,
        input logic set
    );
        return set | (cur & ~(wr & ~wbit));
    endfunction

    eiso_pkg::eiso_state_t s_r;
    eiso_pkg::eiso_state_t s_nxt;

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        logic [5:0]                  idx;
        logic                        hit;
        logic                        done;
        logic                        wr;
        logic                        active;
        logic                        detect;
        logic                        ev_irq;
        logic                        flag_v;
        logic [7:0]                  rd;
        logic [eiso_pkg::CNT_W-1:0]  lim;
        logic [eiso_pkg::IRQ_W-1:0]  ev_set;
        s_nxt  = s_r;
        idx    = paddr[7:2];
        hit    = 1'b0;
        rd     = 8'h00;
        detect = 1'b0;

        // Register read view; unused bits read as zero
        case (idx)
            eiso_pkg::IDX_FLAGS:    begin
                hit = 1'b1;
                rd  = s_r.flags;
            end
            eiso_pkg::IDX_EV_CTRL:  begin
                hit = 1'b1;
                rd  = s_r.ev_ctrl;
            end
            eiso_pkg::IDX_EV_DET:   begin
                hit = 1'b1;
                rd[eiso_pkg::ED_HIST] = s_r.hist;
                rd[eiso_pkg::ED_MON]  = event_input_pin;
            end
            eiso_pkg::IDX_KEY:      begin
                hit = 1'b1;
                rd  = s_r.key;
            end
            eiso_pkg::IDX_CFG:      begin
                hit = 1'b1;
                rd  = s_r.cfg;
            end
            eiso_pkg::IDX_IRQ_STAT: begin
                hit = 1'b1;
                rd  = {5'h00, s_r.irq_stat};
            end
            eiso_pkg::IDX_IRQ_MASK: begin
                hit = 1'b1;
                rd  = {5'h00, s_r.irq_mask};
            end
            default:                begin
                hit = 1'b0;
                rd  = 8'h00;
            end
        endcase
        if (paddr[1:0] != 2'h0) begin
            hit = 1'b0;
        end

        // One wait state: answer is registered, effects land at the
        // edge where the master samples pready high.
        done = psel & penable & s_r.pready;
        wr   = done & pwrite & hit;
        s_nxt.pready  = 1'b0;
        s_nxt.pslverr = 1'b0;
        if (psel && penable && !s_r.pready) begin
            s_nxt.pready  = 1'b1;
            s_nxt.pslverr = ~hit;
            s_nxt.prdata  = pwrite ? 32'h0000_0000 : {24'h00_0000, rd};
        end

        // Plain storage registers
        if (wr && idx == eiso_pkg::IDX_EV_CTRL) begin
            s_nxt.ev_ctrl = pwdata[7:0];
            s_nxt.ev_ctrl[2] = 1'b0;
        end
        if (wr && idx == eiso_pkg::IDX_KEY) begin
            s_nxt.key = pwdata[7:0];
        end
        if (wr && idx == eiso_pkg::IDX_CFG) begin
            s_nxt.cfg = pwdata[7:0] & 8'hCF;
        end
        if (wr && idx == eiso_pkg::IDX_IRQ_MASK) begin
            s_nxt.irq_mask = pwdata[eiso_pkg::IRQ_W-1:0];
        end

        // ************************************************************
        // Event filter
        // ************************************************************
        active = ~(event_input_pin ^ s_r.ev_ctrl[eiso_pkg::EC_LEVEL]);
        lim = deb_limit(s_r.ev_ctrl[eiso_pkg::EC_DEB_HI:
                                    eiso_pkg::EC_DEB_LO]);
        case (s_r.ev_state)
            eiso_pkg::EV_IDLE:  begin
                if (active) begin
                    s_nxt.ev_state = eiso_pkg::EV_COUNT;
                    s_nxt.cnt      = eiso_pkg::CNT_W'(1);
                end
            end
            eiso_pkg::EV_COUNT: begin
                if (!active) begin
                    s_nxt.ev_state = eiso_pkg::EV_IDLE;
                end else if (s_r.cnt >= lim) begin
                    s_nxt.ev_state = eiso_pkg::EV_HELD;
                    detect         = 1'b1;
                end else begin
                    s_nxt.cnt = s_r.cnt + eiso_pkg::CNT_W'(1);
                end
            end
            eiso_pkg::EV_HELD:  begin
                // One event per active stretch
                if (!active) begin
                    s_nxt.ev_state = eiso_pkg::EV_IDLE;
                end
            end
            default:            begin
                s_nxt.ev_state = eiso_pkg::EV_IDLE;
            end
        endcase

        // ************************************************************
        // Flags
        // ************************************************************
        // history set by event, cleared by writing 0
        s_nxt.hist = w0c(s_r.hist,
                         wr && idx == eiso_pkg::IDX_EV_DET,
                         pwdata[eiso_pkg::ED_HIST], detect);
        s_nxt.flags = 8'h00;
        s_nxt.flags[eiso_pkg::FL_UPDATE] = w0c(
            s_r.flags[eiso_pkg::FL_UPDATE],
            wr && idx == eiso_pkg::IDX_FLAGS,
            pwdata[eiso_pkg::FL_UPDATE], flag_set.update);
        s_nxt.flags[eiso_pkg::FL_TIMER] = w0c(
            s_r.flags[eiso_pkg::FL_TIMER],
            wr && idx == eiso_pkg::IDX_FLAGS,
            pwdata[eiso_pkg::FL_TIMER], flag_set.timer);
        s_nxt.flags[eiso_pkg::FL_ALARM] = w0c(
            s_r.flags[eiso_pkg::FL_ALARM],
            wr && idx == eiso_pkg::IDX_FLAGS,
            pwdata[eiso_pkg::FL_ALARM], flag_set.alarm);
        s_nxt.flags[eiso_pkg::FL_SUPPLY] = w0c(
            s_r.flags[eiso_pkg::FL_SUPPLY],
            wr && idx == eiso_pkg::IDX_FLAGS,
            pwdata[eiso_pkg::FL_SUPPLY], flag_set.supply_loss);
        s_nxt.flags[eiso_pkg::FL_LOWV] = w0c(
            s_r.flags[eiso_pkg::FL_LOWV],
            wr && idx == eiso_pkg::IDX_FLAGS,
            pwdata[eiso_pkg::FL_LOWV], flag_set.low_voltage);

        // Sticky event status, read-to-clear; a new event wins
        ev_set = '0;
        ev_set[eiso_pkg::IRQ_EVENT]  = detect;
        ev_set[eiso_pkg::IRQ_SUPPLY] = flag_set.supply_loss;
        ev_set[eiso_pkg::IRQ_LOWV]   = flag_set.low_voltage;
        if (done && !pwrite && hit && idx == eiso_pkg::IDX_IRQ_STAT) begin
            s_nxt.irq_stat = ev_set;
        end else begin
            s_nxt.irq_stat = s_r.irq_stat | ev_set;
        end
        s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);

        // ************************************************************
        // Interrupt pin
        // ************************************************************
        // history gated by enable, no timeout
        ev_irq = s_nxt.hist & s_nxt.ev_ctrl[eiso_pkg::EC_IRQ_EN];
        s_nxt.int_oe   = ev_irq | irq_req.wakeup | irq_req.alarm
                       | irq_req.update;

        // ************************************************************
        // Status output pin
        // ************************************************************
        // selected flag, optionally inverted
        flag_v = sel_flag(s_nxt.cfg[eiso_pkg::CF_FS_HI:eiso_pkg::CF_FS_LO],
                          s_nxt.flags, s_nxt.hist)
               ^ s_nxt.cfg[eiso_pkg::CF_INVERT];
        if (!fs_valid(s_nxt.cfg[eiso_pkg::CF_FS_HI:eiso_pkg::CF_FS_LO])) begin
            flag_v = 1'b0;
        end
        s_nxt.status_o = s_nxt.cfg[eiso_pkg::CF_DIRECT]
                       ? s_nxt.cfg[eiso_pkg::CF_LEVEL] : flag_v;
        s_nxt.status_oe = (s_nxt.key == eiso_pkg::UNLOCK_KEY);
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_r          <= '0;
            s_r.ev_state <= eiso_pkg::EV_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata               = s_r.prdata;
    assign pready               = s_r.pready;
    assign pslverr              = s_r.pslverr;
    // Open drain: only ever pulls low
    assign int_o                = 1'b0;
    assign int_oe               = s_r.int_oe;
    assign status_output_pin_o  = s_r.status_o;
    assign status_output_pin_oe = s_r.status_oe;
    assign irq                  = s_r.irq;

endmodule // eiso_core

`default_nettype wire

// *** eiso_host.sv ***
// Host-side view of the interrupt and status pins of eiso_core.
// Assumes a pull-up on the interrupt line and none on the status line.
`timescale 1ns/1ps
`default_nettype none
module eiso_host (
    input  wire logic clk_sys,
    input  wire logic int_o,
    input  wire logic int_oe,
    input  wire logic status_o,
    input  wire logic status_oe,
    output logic      int_line,
    output logic      status_line
);
    logic last_r;
    assign int_line = int_oe ? int_o : 1'h1;
    // Released line must not keep showing the last driven level
    assign status_line = status_oe ? status_o : ~last_r;
    always_ff @(posedge clk_sys) begin
        if (status_oe) begin
            last_r <= status_o;
        end
    end
endmodule // eiso_host
`default_nettype wire

// *** eiso_core_sva.sv ***
// Concurrent checks on the eiso_core ports, bound to every instance.
// Assumes an APB master that holds each request until pready.
`timescale 1ns/1ps
`default_nettype none
module eiso_core_sva #(
    parameter int unsigned NOFILT_CYC = eiso_pkg::NOFILT_CYC,
    parameter int unsigned FILT1_CYC  = eiso_pkg::FILT1_CYC,
    parameter int unsigned FILT2_CYC  = eiso_pkg::FILT2_CYC,
    parameter int unsigned FILT3_CYC  = eiso_pkg::FILT3_CYC
) (
    input wire logic                    clk_sys,
    input wire logic                    sys_rst,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [7:0]              paddr,
    input wire logic [31:0]             pwdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    input wire eiso_pkg::eiso_irq_req_t irq_req,
    input wire logic                    int_o,
    input wire logic                    int_oe,
    input wire logic                    status_output_pin_o,
    input wire logic                    status_output_pin_oe
);
    logic wr_any, wr_key, wr_cfg, wr_ctl, key_ok_r, key_ok_nxt;
    assign wr_any = psel && penable && pready && pwrite && !pslverr;
    assign wr_key = wr_any && paddr == {eiso_pkg::IDX_KEY, 2'h0};
    assign wr_cfg = wr_any && paddr == {eiso_pkg::IDX_CFG, 2'h0};
    assign wr_ctl = wr_any && paddr == {eiso_pkg::IDX_EV_CTRL, 2'h0};
    always_comb begin
        key_ok_nxt = key_ok_r;
        if (wr_key) begin
            key_ok_nxt = pwdata[7:0] == eiso_pkg::UNLOCK_KEY;
        end
    end
    always_ff @(posedge clk_sys) begin
        key_ok_r <= sys_rst ? 1'h0 : key_ok_nxt;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // ****************************************************************
    // Properties
    // ****************************************************************
    a_apb_wait:
    assert property (psel && penable && !pready |=> pready)
        else $error("pready missing after first access cycle");
    a_pready_pulse:
    assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_int_drain:
    assert property (int_o == 1'h0) else $error("interrupt pin driven high");
    a_irq_or:
    assert property (|irq_req |=> int_oe)
        else $error("other source did not pull interrupt low");
    a_key_open:
    assert property (wr_key && pwdata[7:0] == eiso_pkg::UNLOCK_KEY
        |-> ##2 status_output_pin_oe) else $error("status pin not driven");
    a_key_lock:
    assert property (wr_key && pwdata[7:0] != eiso_pkg::UNLOCK_KEY
        |-> ##2 !status_output_pin_oe) else $error("status pin not released");
    a_direct_lvl:
    assert property (wr_cfg && pwdata[7] && key_ok_r |-> ##2
        status_output_pin_o == $past(pwdata[6], 2) && status_output_pin_oe)
        else $error("direct level not on status pin");
    a_int_hold:
    assert property (int_oe && !$past(|irq_req) && !wr_any |=> int_oe)
        else $error("event interrupt released by itself");
    a_en_clear:
    assert property (wr_ctl && !pwdata[3] ##1 !(|irq_req) |=> !int_oe)
        else $error("interrupt held after enable cleared");
    c_int: cover property ($rose(int_oe));
    c_err: cover property (pslverr);
    c_st: cover property ($rose(status_output_pin_oe));
endmodule // eiso_core_sva
bind eiso_core eiso_core_sva #(
    .NOFILT_CYC(NOFILT_CYC), .FILT1_CYC(FILT1_CYC),
    .FILT2_CYC(FILT2_CYC), .FILT3_CYC(FILT3_CYC)
) u_sva (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .irq_req(irq_req), .int_o(int_o),
    .int_oe(int_oe), .status_output_pin_o(status_output_pin_o),
    .status_output_pin_oe(status_output_pin_oe)
);
`default_nettype wire

// *** test_event_input_and_status_output.sv ***
// Self-checking bench for eiso_core with a host pin model.
// Assumes filter counts shortened through the core parameters.
`timescale 1ns/1ps
`default_nettype none
module test_event_input_and_status_output;
    localparam int unsigned LIM [4] = '{8, 20, 40, 80};
    localparam logic [5:0] A_FL = eiso_pkg::IDX_FLAGS;
    localparam logic [5:0] A_CTL = eiso_pkg::IDX_EV_CTRL;
    localparam logic [5:0] A_DET = eiso_pkg::IDX_EV_DET;
    localparam logic [5:0] A_KEY = eiso_pkg::IDX_KEY;
    localparam logic [5:0] A_CFG = eiso_pkg::IDX_CFG;
    localparam logic [5:0] A_IST = eiso_pkg::IDX_IRQ_STAT;
    localparam logic [5:0] A_IMK = eiso_pkg::IDX_IRQ_MASK;
    localparam logic [7:0] KEY = eiso_pkg::UNLOCK_KEY;
    logic        clk_sys = 1'h0, sys_rst = 1'h1, ev = 1'h1;
    logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic        pready, pslverr, erv, int_o, int_oe, so, soe, irq;
    logic        line_int, line_st;
    eiso_pkg::eiso_flag_set_t flag_set = '0;
    eiso_pkg::eiso_irq_req_t  irq_req = '0;
    int          bad_count = 0, check_count = 0, cyc = 0;
    eiso_core #(.NOFILT_CYC(LIM[0]), .FILT1_CYC(LIM[1]),
        .FILT2_CYC(LIM[2]), .FILT3_CYC(LIM[3])) DUT (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .event_input_pin(ev), .flag_set(flag_set), .irq_req(irq_req),
        .int_o(int_o), .int_oe(int_oe), .status_output_pin_o(so),
        .status_output_pin_oe(soe), .irq(irq));
    eiso_host HOST (.clk_sys(clk_sys), .int_o(int_o), .int_oe(int_oe),
        .status_o(so), .status_oe(soe), .int_line(line_int),
        .status_line(line_st));
    always #4 clk_sys = ~clk_sys;
    // Hang guard: the full run needs under a thousand cycles
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            complete_run();
        end
    end
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input string nm, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [5:0] i,
                       input logic [7:0] d);
        @(posedge clk_sys);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= {i, 2'h0};
        pwdata  <= {24'h0, d};
        @(posedge clk_sys);
        penable <= 1'h1;
        do @(posedge clk_sys); while (pready !== 1'h1);
        rdv = prdata;
        erv = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        apb(1'h1, i, d);
    endtask
    task automatic rd(input string nm, input logic [5:0] i,
                      input logic [7:0] e);
        apb(1'h0, i, 8'h00);
        chk(nm, {24'h0, e}, rdv);
    endtask
    task automatic pin(input logic v, input int n);
        @(posedge clk_sys);
        ev <= v;
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic int_is(input string nm, input logic e, input int n);
        repeat (n) begin
            @(negedge clk_sys);
            if (line_int === e) break;
        end
        chk(nm, {31'h0, e}, {31'h0, line_int});
    endtask
    task automatic st_is(input string nm, input logic [1:0] e);
        repeat (3) @(negedge clk_sys);
        chk(nm, {30'h0, e}, {30'h0, soe, soe & line_st});
    endtask
    task automatic cfg_set(input logic [7:0] v);
        wr(A_KEY, 8'h00);
        wr(A_CFG, v);
        wr(A_KEY, KEY);
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_regs();
        rd("key reset", A_KEY, 8'h00);
        wr(A_CTL, 8'hB7);
        rd("ctrl", A_CTL, 8'hB3);
        wr(A_CTL, 8'h43);
        pin(1'h0, 1);
        rd("monitor low", A_DET, 8'h00);
        pin(1'h1, 1);
        wr(A_DET, 8'h00);
        rd("monitor high", A_DET, 8'h08);
        wr(A_CTL, 8'h00);
        apb(1'h0, 6'h3F, 8'h00);
        chk("unmapped err", 32'h1, {31'h0, erv});
        chk("unmapped data", 32'h0, rdv);
        $display("test regs done");
    endtask
    task automatic t_evt();
        wr(A_IMK, 8'h00);
        wr(A_CTL, 8'h08);
        pin(1'h0, LIM[0] - 3);
        pin(1'h1, 4);
        int_is("short pulse", 1'h1, 1);
        pin(1'h0, LIM[0] + 3);
        pin(1'h1, 1);
        int_is("event int", 1'h0, 4);
        repeat (30) @(posedge clk_sys);
        int_is("int held", 1'h0, 1);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(A_IMK, 8'h01);
        repeat (2) @(negedge clk_sys);
        chk("irq raised", 32'h1, {31'h0, irq});
        rd("irq stat", A_IST, 8'h01);
        repeat (2) @(negedge clk_sys);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rd("history", A_DET, 8'h88);
        wr(A_DET, 8'h80);
        int_is("keep hist", 1'h0, 4);
        wr(A_DET, 8'h00);
        int_is("clear hist", 1'h1, 4);
        $display("test event done");
    endtask
    task automatic t_en();
        wr(A_CTL, 8'h00);
        pin(1'h0, LIM[0] + 3);
        pin(1'h1, 4);
        int_is("disabled", 1'h1, 1);
        rd("hist set", A_DET, 8'h88);
        wr(A_CTL, 8'h08);
        int_is("enabled", 1'h0, 4);
        wr(A_CTL, 8'h00);
        int_is("enable off", 1'h1, 4);
        wr(A_DET, 8'h00);
        $display("test enable done");
    endtask
    task automatic t_deb();
        for (int c = 1; c < 4; c++) begin
            wr(A_CTL, 8'(c));
            pin(1'h0, LIM[c] - 4);
            pin(1'h1, 2);
            rd("deb short", A_DET, 8'h08);
            pin(1'h0, LIM[c] + 4);
            pin(1'h1, 2);
            rd("deb long", A_DET, 8'h88);
            wr(A_DET, 8'h00);
        end
        wr(A_CTL, 8'h00);
        $display("test debounce done");
    endtask
    task automatic t_st();
        wr(A_KEY, 8'h00);
        @(posedge clk_sys);
        flag_set <= 5'h0A;
        @(posedge clk_sys);
        flag_set <= 5'h00;
        rd("flags set", A_FL, 8'h12);
        cfg_set(8'h0D);
        st_is("supply drop", 2'h2);
        wr(A_KEY, 8'h00);
        st_is("locked", 2'h0);
        wr(A_FL, 8'h39);
        rd("flags kept", A_FL, 8'h10);
        wr(A_KEY, KEY);
        st_is("supply clear", 2'h3);
        cfg_set(8'h00);
        st_is("timer sel", 2'h3);
        cfg_set(8'h01);
        st_is("alarm sel", 2'h2);
        cfg_set(8'hC0);
        st_is("direct high", 2'h3);
        wr(A_CFG, 8'h88);
        st_is("direct low", 2'h2);
        wr(A_KEY, 8'h68);
        st_is("bad key", 2'h0);
        $display("test status done");
    endtask
    task automatic t_or();
        for (int k = 0; k < 3; k++) begin
            @(posedge clk_sys);
            irq_req <= 3'h1 << k;
            int_is("or low", 1'h0, 4);
            @(posedge clk_sys);
            irq_req <= 3'h0;
            int_is("or free", 1'h1, 4);
        end
        $display("test shared line done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'h0;
        t_regs();
        t_evt();
        t_en();
        t_deb();
        t_st();
        t_or();
        complete_run();
    end
endmodule // test_event_input_and_status_output
`default_nettype wire
